/* verilog/psi_map.svh */
`ifndef PSI_MAP_SVH
`define PSI_MAP_SVH

// Register offsets on the management port.
`define PSI_ADDR_W 5
`define PSI_OFF_IRQ_EN 5'h12
`define PSI_OFF_STATUS 5'h13
`define PSI_OFF_IND_CFG 5'h14

// Interrupt enable register fields.
`define PSI_IE_TEST 0
`define PSI_IE_GLOBAL 1
`define PSI_IE_RSVD 2
`define PSI_IE_LINK_MSK 4
`define PSI_IE_DUP_MSK 5
`define PSI_IE_SPD_MSK 6
`define PSI_IE_AN_MSK 7
`define PSI_IE_RST 8'h00

// Status change register fields.
`define PSI_SC_PEND 2
`define PSI_SC_LINK 4
`define PSI_SC_DUP 5
`define PSI_SC_SPD 6
`define PSI_SC_AN 7

// Indicator configuration register fields.
`define PSI_IC_ONE_HI 15
`define PSI_IC_ONE_LO 12
`define PSI_IC_TWO_HI 11
`define PSI_IC_TWO_LO 8
`define PSI_IC_DUR_HI 3
`define PSI_IC_DUR_LO 2
`define PSI_IC_STRETCH 1
`define PSI_IC_RST 16'h0422

// Timing, times in milliseconds.
`define PSI_CLK_HZ 20000000
`define PSI_CYC_PER_MS (`PSI_CLK_HZ / 1000)
`define PSI_STRETCH_A_MS 30
`define PSI_STRETCH_B_MS 60
`define PSI_STRETCH_C_MS 100
`define PSI_BLINK_FAST_MS 50
`define PSI_BLINK_SLOW_MS 250
`define PSI_CNT_W 23

`endif

/* verilog/psi_pkg.sv */
`include "psi_map.svh"

package psi_pkg;

  typedef enum logic [3:0] {
    SEL_SPEED = 4'h0,
    SEL_TX = 4'h1,
    SEL_RX = 4'h2,
    SEL_COL = 4'h3,
    SEL_LINK = 4'h4,
    SEL_DUPLEX = 4'h5,
    SEL_UNUSED = 4'h6,
    SEL_ACT = 4'h7,
    SEL_ON = 4'h8,
    SEL_OFF = 4'h9,
    SEL_FAST = 4'hA,
    SEL_SLOW = 4'hB,
    SEL_LINK_RX = 4'hC,
    SEL_LINK_ACT = 4'hD,
    SEL_CODE_E = 4'hE,
    SEL_CODE_F = 4'hF
  } psi_sel_t;

  typedef struct packed {
    logic [7:0] irqEn;
    logic [15:0] indCfg;
    logic anFlag;
    logic spdFlag;
    logic dupFlag;
    logic lnkFlag;
    logic prevAn;
    logic prevSpd;
    logic prevDup;
    logic prevLnk;
    logic irqPend;
    logic [15:0] rdData;
    logic [`PSI_CNT_W-1:0] fastCnt;
    logic [`PSI_CNT_W-1:0] slowCnt;
    logic fastPhase;
    logic slowPhase;
  } psi_regs_state_t;

  typedef struct packed {
    logic [`PSI_CNT_W-1:0] cnt;
    logic ledOn;
  } psi_ind_state_t;

endpackage

/* verilog/psi_ind_if.sv */
`timescale 1ns/1ps
`default_nettype none
`include "psi_map.svh"

interface psi_ind_if;
  logic linkUp;
  logic fullDuplex;
  logic speed100;
  logic txActive;
  logic rxActive;
  logic collision;
  logic fastPhase;
  logic slowPhase;
  logic pulseStretch;
  logic [`PSI_CNT_W-1:0] stretchCycles;

  modport src (
    output linkUp, fullDuplex, speed100, txActive, rxActive, collision,
    output fastPhase, slowPhase, pulseStretch, stretchCycles
  );
  modport dst (
    input linkUp, fullDuplex, speed100, txActive, rxActive, collision,
    input fastPhase, slowPhase, pulseStretch, stretchCycles
  );
endinterface

`default_nettype wire

/* verilog/psi_indicator.sv */
`timescale 1ns/1ps
`default_nettype none
`include "psi_map.svh"

module psi_indicator (
  input wire logic clk,
  input wire logic rst,
  input wire psi_pkg::psi_sel_t sel,
  input wire logic secondField,
  psi_ind_if.dst bus,
  output logic ledOn
);
  import psi_pkg::*;

  psi_ind_state_t s;
  psi_ind_state_t next_s;
  logic combined;
  logic stretchable;
  logic evt;
  logic doStretch;
  logic held;

  // Codes 1110 and 1111 swap meaning between the two fields.
  function automatic logic isDupCol(input psi_sel_t code, input logic second);
    isDupCol = second ? (code == SEL_CODE_E) : (code == SEL_CODE_F);
  endfunction

  always_comb begin
    next_s = s;
    combined = (sel == SEL_LINK_RX) || (sel == SEL_LINK_ACT) || isDupCol(sel, secondField);
    stretchable = (sel == SEL_TX) || (sel == SEL_RX) || (sel == SEL_COL) || (sel == SEL_ACT);
    case (sel)
      SEL_TX: evt = bus.txActive;
      SEL_RX, SEL_LINK_RX: evt = bus.rxActive;
      SEL_ACT, SEL_LINK_ACT: evt = bus.rxActive | bus.txActive;
      default: evt = isDupCol(sel, secondField) ? bus.collision : 1'b0;
    endcase
    if (sel == SEL_COL) begin
      evt = bus.collision;
    end
    // Combined displays stretch even with the global stretch bit off.
    doStretch = combined | (bus.pulseStretch & stretchable);
    if (doStretch && evt) begin
      next_s.cnt = bus.stretchCycles;
    end else if (s.cnt != '0) begin
      next_s.cnt = s.cnt - `PSI_CNT_W'(1);
    end
    held = evt | (doStretch & (s.cnt != '0));
    case (sel)
      SEL_SPEED: next_s.ledOn = bus.speed100;
      SEL_TX, SEL_RX, SEL_COL, SEL_ACT: next_s.ledOn = held;
      SEL_LINK: next_s.ledOn = bus.linkUp;
      SEL_DUPLEX: next_s.ledOn = bus.fullDuplex;
      SEL_ON: next_s.ledOn = 1'b1;
      SEL_OFF: next_s.ledOn = 1'b0;
      SEL_FAST: next_s.ledOn = bus.fastPhase;
      SEL_SLOW: next_s.ledOn = bus.slowPhase;
      // Secondary event flips the primary level; with link down it blinks from off.
      SEL_LINK_RX, SEL_LINK_ACT: next_s.ledOn = bus.linkUp ^ (held & bus.fastPhase);
      default: begin
        if (isDupCol(sel, secondField)) begin
          next_s.ledOn = bus.fullDuplex ^ (held & bus.fastPhase);
        end else begin
          next_s.ledOn = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign ledOn = s.ledOn;

  AST_FORCE_ON: assert property (@(posedge clk) disable iff (rst)
    (sel == SEL_ON) |=> ledOn)
    else $error("Indicator not on in force-on mode.");

  AST_FORCE_OFF: assert property (@(posedge clk) disable iff (rst)
    (sel == SEL_OFF) |=> !ledOn)
    else $error("Indicator not off in force-off mode.");

  AST_COMBINED_STRETCH: assert property (@(posedge clk) disable iff (rst)
    (combined && evt && !bus.pulseStretch) |=> (s.cnt != '0))
    else $error("Combined display event was not stretched.");

  AST_LINK_SOLID: assert property (@(posedge clk) disable iff (rst)
    ((sel == SEL_LINK_RX) && bus.linkUp && !held) |=> ledOn)
    else $error("Link-combined display not solid while link is up.");

endmodule

`default_nettype wire

/* verilog/psi_regs.sv */
// Functional notes
// - Global enable gates all change interrupts but not the test bit, resets zero.
// - Test bit forces interrupt output low.
// - Autoneg done flag, read only, self clearing.
// - Speed change flag sticky until status read.
// - Duplex change flag latched, cleared by read.
// - Link change flag latched, cleared by read.
// - Pending bit shows management interrupt pending.
// - Field one codes 0000 through 0111 decoded.
// - Test codes on, off, fast, slow.
// - Field one combined codes 1100, 1101, 1111.
// - Field two shares encodings, resets to link.
// - Field two 1110 duplex-collision, 1111 unused.
// - Link solid on, secondary event toggles.
// - Activity blinks even with link down.
// - Duplex solid on, collision toggles.
// - Combined displays always stretched.
// - Per-event masks enable interrupt causes.
// - Stretch duration 30, 60, 100 ms.
// - Global stretch bit, resets to one.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "psi_map.svh"

module psi_regs #(
  parameter int unsigned STRETCH_A_CYC = `PSI_STRETCH_A_MS * `PSI_CYC_PER_MS,
  parameter int unsigned STRETCH_B_CYC = `PSI_STRETCH_B_MS * `PSI_CYC_PER_MS,
  parameter int unsigned STRETCH_C_CYC = `PSI_STRETCH_C_MS * `PSI_CYC_PER_MS,
  parameter int unsigned BLINK_FAST_CYC = `PSI_BLINK_FAST_MS * `PSI_CYC_PER_MS,
  parameter int unsigned BLINK_SLOW_CYC = `PSI_BLINK_SLOW_MS * `PSI_CYC_PER_MS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`PSI_ADDR_W-1:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdData,
  input wire logic autonegDone,
  input wire logic speed100,
  input wire logic fullDuplex,
  input wire logic linkUp,
  input wire logic txActive,
  input wire logic rxActive,
  input wire logic collision,
  output logic mgmtIrqN,
  output logic indicatorOneOn,
  output logic indicatorTwoOn
);
  import psi_pkg::*;

  localparam logic [`PSI_CNT_W-1:0] STRETCH_A = `PSI_CNT_W'(STRETCH_A_CYC);
  localparam logic [`PSI_CNT_W-1:0] STRETCH_B = `PSI_CNT_W'(STRETCH_B_CYC);
  localparam logic [`PSI_CNT_W-1:0] STRETCH_C = `PSI_CNT_W'(STRETCH_C_CYC);
  localparam logic [`PSI_CNT_W-1:0] FAST_LAST = `PSI_CNT_W'(BLINK_FAST_CYC - 1);
  localparam logic [`PSI_CNT_W-1:0] SLOW_LAST = `PSI_CNT_W'(BLINK_SLOW_CYC - 1);

  psi_regs_state_t s;
  psi_regs_state_t next_s;
  logic wrIe;
  logic wrCfg;
  logic rdStatus;
  logic anEvt;
  logic spdEvt;
  logic dupEvt;
  logic lnkEvt;

  psi_ind_if indBus ();

  // A change seen in the clearing cycle still sets the flag, so it
  // survives into the next read instead of being swallowed.
  function automatic logic stickyNext(input logic evt, input logic flag, input logic clr);
    stickyNext = evt | (flag & ~clr);
  endfunction

  function automatic logic irqFor(input psi_regs_state_t st);
    logic cause;
    cause = (st.irqEn[`PSI_IE_AN_MSK] & st.anFlag)
          | (st.irqEn[`PSI_IE_SPD_MSK] & st.spdFlag)
          | (st.irqEn[`PSI_IE_DUP_MSK] & st.dupFlag)
          | (st.irqEn[`PSI_IE_LINK_MSK] & st.lnkFlag);
    irqFor = (st.irqEn[`PSI_IE_GLOBAL] & cause) | st.irqEn[`PSI_IE_TEST];
  endfunction

  function automatic logic [`PSI_CNT_W-1:0] stretchLen(input logic [1:0] code);
    case (code)
      2'h0: stretchLen = STRETCH_A;
      2'h1: stretchLen = STRETCH_B;
      default: stretchLen = STRETCH_C;
    endcase
  endfunction

  always_comb begin
    next_s = s;
    wrIe = regWr && (regAddr == `PSI_OFF_IRQ_EN);
    wrCfg = regWr && (regAddr == `PSI_OFF_IND_CFG);
    rdStatus = regRd && (regAddr == `PSI_OFF_STATUS);

    if (wrIe) begin
      next_s.irqEn = regWrData[7:0];
    end
    if (wrCfg) begin
      next_s.indCfg = regWrData;
    end

    anEvt = autonegDone & ~s.prevAn;
    spdEvt = speed100 ^ s.prevSpd;
    dupEvt = fullDuplex ^ s.prevDup;
    lnkEvt = linkUp ^ s.prevLnk;
    next_s.prevAn = autonegDone;
    next_s.prevSpd = speed100;
    next_s.prevDup = fullDuplex;
    next_s.prevLnk = linkUp;
    next_s.anFlag = stickyNext(anEvt, s.anFlag, rdStatus);
    next_s.spdFlag = stickyNext(spdEvt, s.spdFlag, rdStatus);
    next_s.dupFlag = stickyNext(dupEvt, s.dupFlag, rdStatus);
    next_s.lnkFlag = stickyNext(lnkEvt, s.lnkFlag, rdStatus);
    next_s.irqPend = irqFor(next_s);

    next_s.rdData = '0;
    if (regRd) begin
      case (regAddr)
        `PSI_OFF_IRQ_EN: next_s.rdData = {8'h00, s.irqEn};
        `PSI_OFF_STATUS: begin
          next_s.rdData[`PSI_SC_AN] = s.anFlag;
          next_s.rdData[`PSI_SC_SPD] = s.spdFlag;
          next_s.rdData[`PSI_SC_DUP] = s.dupFlag;
          next_s.rdData[`PSI_SC_LINK] = s.lnkFlag;
          next_s.rdData[`PSI_SC_PEND] = s.irqPend;
        end
        `PSI_OFF_IND_CFG: next_s.rdData = s.indCfg;
        default: next_s.rdData = '0;
      endcase
    end

    // Blink phases come from free-running dividers on the device clock.
    if (s.fastCnt == FAST_LAST) begin
      next_s.fastCnt = '0;
      next_s.fastPhase = ~s.fastPhase;
    end else begin
      next_s.fastCnt = s.fastCnt + `PSI_CNT_W'(1);
    end
    if (s.slowCnt == SLOW_LAST) begin
      next_s.slowCnt = '0;
      next_s.slowPhase = ~s.slowPhase;
    end else begin
      next_s.slowCnt = s.slowCnt + `PSI_CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.irqEn <= `PSI_IE_RST;
      s.indCfg <= `PSI_IC_RST;
    end else begin
      s <= next_s;
    end
  end

  assign indBus.linkUp = linkUp;
  assign indBus.fullDuplex = fullDuplex;
  assign indBus.speed100 = speed100;
  assign indBus.txActive = txActive;
  assign indBus.rxActive = rxActive;
  assign indBus.collision = collision;
  assign indBus.fastPhase = s.fastPhase;
  assign indBus.slowPhase = s.slowPhase;
  assign indBus.pulseStretch = s.indCfg[`PSI_IC_STRETCH];
  assign indBus.stretchCycles = stretchLen(s.indCfg[`PSI_IC_DUR_HI:`PSI_IC_DUR_LO]);

  psi_indicator indOne (
    .clk(clk),
    .rst(rst),
    .sel(psi_sel_t'(s.indCfg[`PSI_IC_ONE_HI:`PSI_IC_ONE_LO])),
    .secondField(1'b0),
    .bus(indBus.dst),
    .ledOn(indicatorOneOn)
  );

  psi_indicator indTwo (
    .clk(clk),
    .rst(rst),
    .sel(psi_sel_t'(s.indCfg[`PSI_IC_TWO_HI:`PSI_IC_TWO_LO])),
    .secondField(1'b1),
    .bus(indBus.dst),
    .ledOn(indicatorTwoOn)
  );

  assign regRdData = s.rdData;
  assign mgmtIrqN = ~s.irqPend;

  AST_GLOBAL_OFF: assert property (@(posedge clk) disable iff (rst)
    (!s.irqEn[`PSI_IE_GLOBAL] && !s.irqEn[`PSI_IE_TEST]) |-> mgmtIrqN)
    else $error("Interrupt asserted with global enable off.");

  AST_TEST_FORCE: assert property (@(posedge clk) disable iff (rst)
    (wrIe && regWrData[`PSI_IE_TEST]) |=> !mgmtIrqN)
    else $error("Test force did not assert the interrupt.");

  AST_SPEED_SET: assert property (@(posedge clk) disable iff (rst)
    (speed100 != s.prevSpd) |=> s.spdFlag)
    else $error("Speed change not latched.");

  AST_SPEED_HOLD: assert property (@(posedge clk) disable iff (rst)
    (s.spdFlag && !rdStatus) |=> s.spdFlag)
    else $error("Speed change flag dropped without a read.");

  AST_LINK_CLEAR: assert property (@(posedge clk) disable iff (rst)
    (rdStatus && (linkUp == s.prevLnk)) |=> !s.lnkFlag)
    else $error("Link change flag not cleared by status read.");

  AST_DUP_KEEP: assert property (@(posedge clk) disable iff (rst)
    (rdStatus && (fullDuplex != s.prevDup)) |=>
      (s.dupFlag && (regRdData[`PSI_SC_DUP] == $past(s.dupFlag))))
    else $error("Duplex change during read was lost or misreported.");

  AST_AN_SET: assert property (@(posedge clk) disable iff (rst)
    $rose(autonegDone) && $past(autonegDone) == s.prevAn |=> s.anFlag)
    else $error("Autoneg completion not flagged.");

  AST_PEND_BIT: assert property (@(posedge clk) disable iff (rst)
    rdStatus |=> (regRdData[`PSI_SC_PEND] == $past(s.irqEn[`PSI_IE_TEST] | (s.irqEn[`PSI_IE_GLOBAL]
      & |(s.irqEn[`PSI_IE_AN_MSK:`PSI_IE_LINK_MSK] & {s.anFlag, s.spdFlag, s.dupFlag, s.lnkFlag})))))
    else $error("Pending bit does not match interrupt state.");

  AST_MASKED_IRQ: assert property (@(posedge clk) disable iff (rst)
    (s.lnkFlag && s.irqEn[`PSI_IE_LINK_MSK] && s.irqEn[`PSI_IE_GLOBAL]) |-> !mgmtIrqN)
    else $error("Enabled link change did not raise the interrupt.");

  AST_RD_ONE_CYCLE: assert property (@(posedge clk) disable iff (rst)
    !regRd |=> (regRdData == 16'h0000))
    else $error("Read data present outside the answer cycle.");

  AST_DUP_SET: assert property (@(posedge clk) disable iff (rst)
    (fullDuplex != s.prevDup) |=> s.dupFlag)
    else $error("Duplex change not latched.");

  AST_LINK_SET: assert property (@(posedge clk) disable iff (rst)
    (linkUp != s.prevLnk) |=> s.lnkFlag)
    else $error("Link change not latched.");

  AST_DUP_HOLD: assert property (@(posedge clk) disable iff (rst)
    (s.dupFlag && !rdStatus) |=> s.dupFlag)
    else $error("Duplex change flag dropped without a read.");

  AST_LINK_HOLD: assert property (@(posedge clk) disable iff (rst)
    (s.lnkFlag && !rdStatus) |=> s.lnkFlag)
    else $error("Link change flag dropped without a read.");

  AST_AN_HOLD: assert property (@(posedge clk) disable iff (rst)
    (s.anFlag && !rdStatus) |=> s.anFlag)
    else $error("Autoneg flag dropped without a read.");

  AST_SPEED_CLEAR: assert property (@(posedge clk) disable iff (rst)
    (rdStatus && (speed100 == s.prevSpd)) |=> !s.spdFlag)
    else $error("Speed change flag not cleared by status read.");

  AST_DUP_CLEAR: assert property (@(posedge clk) disable iff (rst)
    (rdStatus && (fullDuplex == s.prevDup)) |=> !s.dupFlag)
    else $error("Duplex change flag not cleared by status read.");

  AST_AN_CLEAR: assert property (@(posedge clk) disable iff (rst)
    (rdStatus && !anEvt) |=> !s.anFlag)
    else $error("Autoneg flag not cleared by status read.");

  AST_STATUS_BITS: assert property (@(posedge clk) disable iff (rst)
    rdStatus |=> (regRdData[`PSI_SC_AN:`PSI_SC_LINK] == $past({s.anFlag, s.spdFlag, s.dupFlag,
      s.lnkFlag})))
    else $error("Status read does not report the change flags.");

  AST_STATUS_RSVD: assert property (@(posedge clk) disable iff (rst)
    rdStatus |=> ((regRdData & 16'hFF0B) == 16'h0000))
    else $error("Reserved status bits read nonzero.");

  AST_TEST_HOLD: assert property (@(posedge clk) disable iff (rst)
    s.irqEn[`PSI_IE_TEST] |-> !mgmtIrqN)
    else $error("Interrupt released while test force is set.");

  AST_IRQ_RELEASE: assert property (@(posedge clk) disable iff (rst)
    (rdStatus && !regWr && !s.irqEn[`PSI_IE_TEST] && !anEvt && !spdEvt && !dupEvt && !lnkEvt)
      |=> mgmtIrqN)
    else $error("Interrupt not released after status read.");

  AST_IE_WRITE: assert property (@(posedge clk) disable iff (rst)
    wrIe |=> (s.irqEn == $past(regWrData[7:0])))
    else $error("Interrupt enable write not stored.");

  AST_CFG_WRITE: assert property (@(posedge clk) disable iff (rst)
    wrCfg |=> (s.indCfg == $past(regWrData)))
    else $error("Indicator configuration write not stored.");

  AST_RD_IE: assert property (@(posedge clk) disable iff (rst)
    (regRd && (regAddr == `PSI_OFF_IRQ_EN)) |=> (regRdData == {8'h00, $past(s.irqEn)}))
    else $error("Interrupt enable readback wrong.");

  AST_RD_CFG: assert property (@(posedge clk) disable iff (rst)
    (regRd && (regAddr == `PSI_OFF_IND_CFG)) |=> (regRdData == $past(s.indCfg)))
    else $error("Indicator configuration readback wrong.");

  AST_FAST_TOGGLE: assert property (@(posedge clk) disable iff (rst)
    (s.fastCnt == FAST_LAST) |=> (s.fastPhase != $past(s.fastPhase)))
    else $error("Fast blink phase did not toggle at the end of its count.");

  AST_FAST_STEADY: assert property (@(posedge clk) disable iff (rst)
    (s.fastCnt != FAST_LAST) |=> $stable(s.fastPhase))
    else $error("Fast blink phase toggled early.");

  AST_SLOW_TOGGLE: assert property (@(posedge clk) disable iff (rst)
    (s.slowCnt == SLOW_LAST) |=> (s.slowPhase != $past(s.slowPhase)))
    else $error("Slow blink phase did not toggle at the end of its count.");

endmodule

`default_nettype wire

/* verif/psi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "psi_map.svh"

// Management host: strobes last one cycle; write data is scrambled once released.
module psi_host_model (
  input wire logic clk,
  output logic [`PSI_ADDR_W-1:0] regAddr,
  output logic [15:0] regWrData,
  output logic regWr,
  output logic regRd,
  input wire logic [15:0] regRdData
);
  initial begin
    regAddr = '0;
    regWrData = '0;
    regWr = 1'b0;
    regRd = 1'b0;
  end

  task automatic wr(input logic [`PSI_ADDR_W-1:0] a, input logic [15:0] d);
    logic [15:0] v;
    v = d;
    if (a == `PSI_OFF_IRQ_EN) v[`PSI_IE_RSVD] = 1'b0;
    @(posedge clk);
    regAddr <= a;
    regWrData <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    regWrData <= ~v;
  endtask

  task automatic rd(input logic [`PSI_ADDR_W-1:0] a, output logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    d = regRdData;
    if (a == `PSI_OFF_IRQ_EN) d[`PSI_IE_RSVD] = 1'b0;
  endtask
endmodule

`default_nettype wire

/* verif/phy_status_irq_and_indicator_select_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "psi_map.svh"

module phy_status_irq_and_indicator_select_bench;
  logic clk;
  logic rst;
  logic [`PSI_ADDR_W-1:0] regAddr;
  logic [15:0] regWrData;
  logic regWr;
  logic regRd;
  logic [15:0] regRdData;
  // Order: autoneg, speed, duplex, link, tx, rx, collision.
  logic [6:0] phy;
  logic mgmtIrqN;
  logic indOne;
  logic indTwo;
  int mismatches;
  int totalChecks;
  int seed;

  psi_regs #(.STRETCH_A_CYC(20), .STRETCH_B_CYC(40), .STRETCH_C_CYC(60),
    .BLINK_FAST_CYC(4), .BLINK_SLOW_CYC(10)) dut (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .autonegDone(phy[6]), .speed100(phy[5]),
    .fullDuplex(phy[4]), .linkUp(phy[3]), .txActive(phy[2]), .rxActive(phy[1]),
    .collision(phy[0]), .mgmtIrqN(mgmtIrqN), .indicatorOneOn(indOne),
    .indicatorTwoOn(indTwo)
  );

  psi_host_model host (
    .clk(clk), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    totalChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic readChk(input logic [`PSI_ADDR_W-1:0] a, input logic [15:0] exp);
    logic [15:0] d;
    host.rd(a, d);
    check(d, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Flags are {autoneg, speed, duplex, link}; all masks and the global enable are set.
  function automatic logic [15:0] statusWord(input logic [3:0] f);
    return {8'h00, f, 1'b0, |f, 2'b00};
  endfunction

  // Counts lit cycles of one indicator over a window.
  task automatic countOn(input bit two, input int n, output logic [15:0] ones);
    ones = '0;
    repeat (n) begin
      cyc(1);
      ones = ones + {15'h0, two ? indTwo : indOne};
    end
  endtask

  logic [3:0] expF;
  logic [3:0] nv;
  logic [15:0] ones;
  logic [15:0] tbl [9];

  initial begin
    repeat (50000) @(posedge clk);
    mismatches++;
    final_report();
  end

  initial begin
    rst = 1'b1;
    phy = '0;
    mismatches = 0;
    totalChecks = 0;
    seed = 32'h5f69;
    expF = '0;
    // Entries: field one code, field two code, expected one, expected two.
    tbl = '{16'h0011, 16'h4400, 16'h5511, 16'h8811, 16'h9900, 16'h6600, 16'hEF00,
      16'hFE11, 16'hCD00};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    check({14'h0, indOne, indTwo}, 16'h0000);
    readChk(`PSI_OFF_IRQ_EN, 16'h0000);
    readChk(`PSI_OFF_IND_CFG, `PSI_IC_RST);
    readChk(`PSI_OFF_STATUS, 16'h0000);
    host.wr(`PSI_OFF_STATUS, 16'hFFFF);
    host.wr(5'h05, 16'hFFFF);
    host.wr(`PSI_OFF_IRQ_EN, 16'hFFFF);
    readChk(`PSI_OFF_IRQ_EN, 16'h00FB);
    check({15'h0, mgmtIrqN}, 16'h0000);
    readChk(5'h05, 16'h0000);
    host.wr(`PSI_OFF_IRQ_EN, 16'h00F0);
    readChk(`PSI_OFF_STATUS, 16'h0000);
    @(posedge clk);
    phy[3] <= 1'b1;
    cyc(3);
    check({15'h0, mgmtIrqN}, 16'h0001);
    readChk(`PSI_OFF_STATUS, 16'h0010);
    host.wr(`PSI_OFF_IRQ_EN, 16'h00F2);
    for (int i = 0; i < 40; i++) begin
      nv = 4'($random(seed));
      @(posedge clk);
      expF[3] = expF[3] | (nv[3] & ~phy[6]);
      expF[2:0] = expF[2:0] | (nv[2:0] ^ phy[5:3]);
      phy[6:3] <= nv;
      if (i % 3 != 0) continue;
      cyc(3);
      check({15'h0, mgmtIrqN}, {15'h0, ~|expF});
      readChk(`PSI_OFF_STATUS, statusWord(expF));
      check({15'h0, mgmtIrqN}, 16'h0001);
      expF = '0;
    end
    // A duplex change in the read cycle must survive into the next read.
    fork
      readChk(`PSI_OFF_STATUS, 16'h0000);
      begin
        @(posedge clk);
        phy[4] <= ~phy[4];
      end
    join
    readChk(`PSI_OFF_STATUS, 16'h0024);
    @(posedge clk);
    phy <= 7'b0110000;
    cyc(3);
    check({14'h0, indOne, indTwo}, 16'h0002);
    foreach (tbl[k]) begin
      host.wr(`PSI_OFF_IND_CFG, {tbl[k][15:8], 8'h22});
      cyc(2);
      check({14'h0, indOne, indTwo}, {14'h0, tbl[k][4], tbl[k][0]});
    end
    host.wr(`PSI_OFF_IND_CFG, 16'h1202);
    @(posedge clk);
    phy[2:1] <= 2'b11;
    @(posedge clk);
    phy[2:1] <= 2'b00;
    cyc(10);
    check({14'h0, indOne, indTwo}, 16'h0003);
    cyc(30);
    check({14'h0, indOne, indTwo}, 16'h0000);
    host.wr(`PSI_OFF_IND_CFG, 16'h3706);
    @(posedge clk);
    phy[2:0] <= 3'b101;
    @(posedge clk);
    phy[2:0] <= 3'b000;
    cyc(30);
    check({14'h0, indOne, indTwo}, 16'h0003);
    cyc(20);
    check({14'h0, indOne, indTwo}, 16'h0000);
    host.wr(`PSI_OFF_IND_CFG, 16'h1D00);
    @(posedge clk);
    phy[2:1] <= 2'b11;
    @(posedge clk);
    phy[2:1] <= 2'b00;
    cyc(3);
    check({15'h0, indOne}, 16'h0000);
    countOn(1'b1, 16, ones);
    check({15'h0, ones != 0}, 16'h0001);
    host.wr(`PSI_OFF_IND_CFG, 16'hCE00);
    @(posedge clk);
    phy[3] <= 1'b1;
    cyc(3);
    check({14'h0, indOne, indTwo}, 16'h0003);
    @(posedge clk);
    phy[1:0] <= 2'b11;
    @(posedge clk);
    phy[1:0] <= 2'b00;
    countOn(1'b0, 16, ones);
    check({15'h0, ones < 16}, 16'h0001);
    @(posedge clk);
    phy[1:0] <= 2'b11;
    @(posedge clk);
    phy[1:0] <= 2'b00;
    countOn(1'b1, 16, ones);
    check({15'h0, ones < 16}, 16'h0001);
    host.wr(`PSI_OFF_IND_CFG, 16'hAB22);
    countOn(1'b0, 16, ones);
    check(ones, 16'h0008);
    countOn(1'b1, 20, ones);
    check(ones, 16'h000A);
    final_report();
  end
endmodule

`default_nettype wire
